/* design/tsem_defs.vh */
// selection codes, affinity masks and widths of the thread-switch event monitor
`ifndef TSEM_DEFS_VH
`define TSEM_DEFS_VH

`define TSEM_SEL_W          12
`define TSEM_AFF_W          20
`define TSEM_CNT_W          5

`define TSEM_SEL_DROP       12'h0139
`define TSEM_SEL_EXPLICIT_DISABLE       12'h013a
`define TSEM_SEL_IMPLICIT_DISABLE       12'h013b
`define TSEM_SEL_HOLD       12'h013c
`define TSEM_SEL_STALL_ANY  12'h013d
`define TSEM_SEL_STALL_SW   12'h013e
`define TSEM_SEL_STALL_PIPE 12'h013f
`define TSEM_SEL_STALL_RSE  12'h0140
`define TSEM_SEL_STALL_REGISTER_CONFLICT_BLOCKER 12'h0141
`define TSEM_SEL_STALL_FLD  12'h0142
`define TSEM_SEL_SAME       12'h0874

`define TSEM_AFF_ODD        20'h5_5550
`define TSEM_AFF_EVEN       20'ha_aaa0
`define TSEM_AFF_SAME       20'h5_0550

`endif

/* design/tsem_decode.v */
// selection-code decoder: event bit and affinity mask for one counter
`timescale 1ns/1ps
`include "tsem_defs.vh"

module tsem_decode (
	input  wire [`TSEM_SEL_W-1:0] sel,
	input  wire [10:0]            ev,
	output reg                    hit,
	output reg  [`TSEM_AFF_W-1:0] aff
);
	// ev order: drop explicit_disable implicit_disable hold any sw pipe rse register_conflict_blocker fld same
	always @* begin
		hit = 1'b0;
		aff = {`TSEM_AFF_W{1'b0}};
		case (sel)
			`TSEM_SEL_DROP:       begin hit = ev[0];  aff = `TSEM_AFF_EVEN; end
			`TSEM_SEL_EXPLICIT_DISABLE:       begin hit = ev[1];  aff = `TSEM_AFF_ODD;  end
			`TSEM_SEL_IMPLICIT_DISABLE:       begin hit = ev[2];  aff = `TSEM_AFF_EVEN; end
			`TSEM_SEL_HOLD:       begin hit = ev[3];  aff = `TSEM_AFF_ODD;  end
			`TSEM_SEL_STALL_ANY:  begin hit = ev[4];  aff = `TSEM_AFF_EVEN; end
			`TSEM_SEL_STALL_SW:   begin hit = ev[5];  aff = `TSEM_AFF_ODD;  end
			`TSEM_SEL_STALL_PIPE: begin hit = ev[6];  aff = `TSEM_AFF_EVEN; end
			`TSEM_SEL_STALL_RSE:  begin hit = ev[7];  aff = `TSEM_AFF_ODD;  end
			`TSEM_SEL_STALL_REGISTER_CONFLICT_BLOCKER: begin hit = ev[8];  aff = `TSEM_AFF_EVEN; end
			`TSEM_SEL_STALL_FLD:  begin hit = ev[9];  aff = `TSEM_AFF_ODD;  end
			`TSEM_SEL_SAME:       begin hit = ev[10]; aff = `TSEM_AFF_SAME; end
			default:              begin hit = 1'b0;   aff = {`TSEM_AFF_W{1'b0}}; end
		endcase
	end
endmodule

/* design/tsem_monitor.v */
// back-end thread-switch event sources with per-counter selection
// What this block does
// RL1 - code 0x13a: cycle with switching off because a thread is low power; mask 0x55550
// RL2 - code 0x13b: cycle with switching off because the switch-disable bit is 1
// RL3 - code 0x139: each dropped switch opportunity, by policy, full slice or wait window
// RL4 - code 0x13c: cycle a pending switch is held by camping or rare condition
// RL5 - stall any 0x13d, blocked by pipeline 0x13f, blocked while in switch 0x13e
// RL6 - stall by register conflict 0x141, floating load 0x142, stack engine 0x140
// RL7 - code 0x874: cycle front and back end share one thread; mask 0x50550
// RL8 - at most one increment per source per cycle; counter must lie in affinity mask
`timescale 1ns/1ps
`include "tsem_defs.vh"

module tsem_monitor #(
	parameter NUM_CNT = `TSEM_CNT_W
) (
	input  wire                            mclk,
	input  wire                            rst_n,
	input  wire [1:0]                      low_power_state,
	input  wire                            switch_disable_bit,
	input  wire                            drop_policy,
	input  wire                            drop_full_slice,
	input  wire                            drop_wait_window,
	input  wire                            switch_pending,
	input  wire                            hold_camping,
	input  wire                            hold_rare,
	input  wire                            stall_pipe,
	input  wire                            stall_in_switch,
	input  wire                            register_conflict_blocker,
	input  wire                            floating_load_blocker,
	input  wire                            register_stack_engine,
	input  wire                            front_end_thread,
	input  wire                            back_end_thread,
	input  wire                            pipe_continuous,
	input  wire [NUM_CNT*`TSEM_SEL_W-1:0]  cnt_sel,
	output reg                             explicit_disable,
	output reg                             implicit_disable,
	output reg                             backend_switch_disabled_event,
	output reg                             backend_switch_dropped_event,
	output reg                             backend_switch_held_event,
	output reg                             backend_switch_stall_event,
	output reg                             front_back_same_thread_event,
	output reg  [NUM_CNT-1:0]              cnt_inc
);
	// =====================================================
	// event vector bit positions
	// =====================================================
	localparam EV_DROP = 0;
	localparam EV_EXPLICIT_DISABLE = 1;
	localparam EV_IMPLICIT_DISABLE = 2;
	localparam EV_HOLD = 3;
	localparam EV_ANY  = 4;
	localparam EV_SW   = 5;
	localparam EV_PIPE = 6;
	localparam EV_RSE  = 7;
	localparam EV_REGISTER_CONFLICT_BLOCKER = 8;
	localparam EV_FLD  = 9;
	localparam EV_SAME = 10;
	localparam EV_W    = 11;

	// =====================================================
	// disable sources
	// =====================================================
	wire explicit_disable_w;
	wire implicit_disable_w;
	assign explicit_disable_w = |low_power_state;   // see RL1
	assign implicit_disable_w = switch_disable_bit; // see RL2

	// =====================================================
	// dropped and held switch opportunities
	// =====================================================
	wire drop_w;
	wire hold_w;
	// several causes in one cycle still give one pulse
	assign drop_w = drop_policy | drop_full_slice | drop_wait_window; // see RL3
	// hold reasons only count while a switch waits
	assign hold_w = switch_pending & (hold_camping | hold_rare); // see RL4

	// =====================================================
	// switch stall causes
	// =====================================================
	wire register_conflict_blocker_w;
	wire fld_w;
	wire rse_w;
	wire any_w;
	assign register_conflict_blocker_w = register_conflict_blocker; // see RL6
	assign fld_w  = floating_load_blocker;     // see RL6
	assign rse_w  = register_stack_engine;     // see RL6
	// any cause: pipeline, in switch, or one of the three units
	assign any_w  = stall_pipe | stall_in_switch | register_conflict_blocker_w | fld_w | rse_w; // see RL5

	// =====================================================
	// front and back end on one thread
	// =====================================================
	wire same_w;
	assign same_w = pipe_continuous & (front_end_thread == back_end_thread); // see RL7

	// =====================================================
	// event vector, one bit per source per cycle
	// =====================================================
	wire [EV_W-1:0] ev_w;
	assign ev_w[EV_DROP] = drop_w;          // see RL8
	assign ev_w[EV_EXPLICIT_DISABLE] = explicit_disable_w;          // see RL8
	assign ev_w[EV_IMPLICIT_DISABLE] = implicit_disable_w;          // see RL8
	assign ev_w[EV_HOLD] = hold_w;          // see RL8
	assign ev_w[EV_ANY]  = any_w;           // see RL8
	assign ev_w[EV_SW]   = stall_in_switch; // see RL5
	assign ev_w[EV_PIPE] = stall_pipe;      // see RL5
	assign ev_w[EV_RSE]  = rse_w;           // see RL8
	assign ev_w[EV_REGISTER_CONFLICT_BLOCKER] = register_conflict_blocker_w;          // see RL8
	assign ev_w[EV_FLD]  = fld_w;           // see RL8
	assign ev_w[EV_SAME] = same_w;          // see RL8

	// =====================================================
	// per-counter selection and affinity gating
	// =====================================================
	wire [NUM_CNT-1:0] inc_d;
	genvar             g;
	generate
		for (g = 0; g < NUM_CNT; g = g + 1) begin : g_cnt
			wire                   hit;
			wire [`TSEM_AFF_W-1:0] aff;
			tsem_decode u_dec (
				.sel (cnt_sel[g*`TSEM_SEL_W +: `TSEM_SEL_W]),
				.ev  (ev_w),
				.hit (hit),
				.aff (aff)
			);
			if (g < `TSEM_AFF_W) begin : g_in_mask
				assign inc_d[g] = hit & aff[g]; // see RL8
			end else begin : g_no_mask
				// a counter past the mask width never qualifies
				assign inc_d[g] = 1'b0;
			end
		end
	endgenerate

	// =====================================================
	// explicit disable flag
	// =====================================================
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			explicit_disable <= 1'b0;
		end else begin
			explicit_disable <= explicit_disable_w; // see RL1
		end
	end

	// =====================================================
	// implicit disable flag
	// =====================================================
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			implicit_disable <= 1'b0;
		end else begin
			implicit_disable <= implicit_disable_w; // see RL2
		end
	end

	// =====================================================
	// switching disabled for either reason
	// =====================================================
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			backend_switch_disabled_event <= 1'b0;
		end else begin
			backend_switch_disabled_event <= explicit_disable_w | implicit_disable_w; // see RL1
		end
	end

	// =====================================================
	// dropped opportunity pulse
	// =====================================================
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			backend_switch_dropped_event <= 1'b0;
		end else begin
			backend_switch_dropped_event <= drop_w; // see RL3
		end
	end

	// =====================================================
	// held switch cycles
	// =====================================================
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			backend_switch_held_event <= 1'b0;
		end else begin
			backend_switch_held_event <= hold_w; // see RL4
		end
	end

	// =====================================================
	// stall cycles, any cause
	// =====================================================
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			backend_switch_stall_event <= 1'b0;
		end else begin
			backend_switch_stall_event <= any_w; // see RL5
		end
	end

	// =====================================================
	// same-thread cycles
	// =====================================================
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			front_back_same_thread_event <= 1'b0;
		end else begin
			front_back_same_thread_event <= same_w; // see RL7
		end
	end

	// =====================================================
	// per-counter increments
	// =====================================================
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_inc <= {NUM_CNT{1'b0}};
		end else begin
			cnt_inc <= inc_d; // see RL8
		end
	end

endmodule

/* bench/tsem_props.sv */
// assertions on the thread-switch event monitor ports
`timescale 1ns/1ps
module tsem_props #(
	parameter NUM_CNT = 5
) (
	input wire logic               mclk,
	input wire logic               rst_n,
	input wire logic [1:0]         low_power_state,
	input wire logic               switch_disable_bit,
	input wire logic               drop_policy,
	input wire logic               drop_full_slice,
	input wire logic               drop_wait_window,
	input wire logic               switch_pending,
	input wire logic               hold_camping,
	input wire logic               hold_rare,
	input wire logic               stall_pipe,
	input wire logic               stall_in_switch,
	input wire logic               register_conflict_blocker,
	input wire logic               floating_load_blocker,
	input wire logic               register_stack_engine,
	input wire logic               front_end_thread,
	input wire logic               back_end_thread,
	input wire logic               pipe_continuous,
	input wire logic               explicit_disable,
	input wire logic               implicit_disable,
	input wire logic               backend_switch_disabled_event,
	input wire logic               backend_switch_dropped_event,
	input wire logic               backend_switch_held_event,
	input wire logic               backend_switch_stall_event,
	input wire logic               front_back_same_thread_event,
	input wire logic [NUM_CNT-1:0] cnt_inc
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	explicit_disable_track_a: assert property (##1 explicit_disable == $past(|low_power_state)) else $error("explicit_disable");
	implicit_disable_track_a: assert property (##1 implicit_disable == $past(switch_disable_bit)) else $error("implicit_disable");
	disable_or_a: assert property (backend_switch_disabled_event == (explicit_disable | implicit_disable))
		else $error("disable");
	held_on_a: assert property (switch_pending && (hold_camping || hold_rare) |=>
		backend_switch_held_event) else $error("held");
	held_off_a: assert property (!switch_pending |=> !backend_switch_held_event) else $error("held");
	same_on_a: assert property (front_end_thread == back_end_thread && pipe_continuous |=>
		front_back_same_thread_event) else $error("same");
	same_off_a: assert property (!pipe_continuous |=> !front_back_same_thread_event) else $error("same");
	low_bits_a: assert property (cnt_inc[3:0] == 4'h0) else $error("mask");
	drop_track_a: assert property (##1
		backend_switch_dropped_event == $past(drop_policy | drop_full_slice | drop_wait_window)) else $error("drop");
	stall_track_a: assert property (##1 backend_switch_stall_event ==
		$past(stall_pipe | stall_in_switch | register_conflict_blocker | floating_load_blocker | register_stack_engine))
		else $error("stall");
endmodule
bind tsem_monitor tsem_props #(
	.NUM_CNT (NUM_CNT)
) tsem_props_i (
	.mclk                          (mclk),
	.rst_n                         (rst_n),
	.low_power_state               (low_power_state),
	.switch_disable_bit            (switch_disable_bit),
	.drop_policy                   (drop_policy),
	.drop_full_slice               (drop_full_slice),
	.drop_wait_window              (drop_wait_window),
	.switch_pending                (switch_pending),
	.hold_camping                  (hold_camping),
	.hold_rare                     (hold_rare),
	.stall_pipe                    (stall_pipe),
	.stall_in_switch               (stall_in_switch),
	.register_conflict_blocker     (register_conflict_blocker),
	.floating_load_blocker         (floating_load_blocker),
	.register_stack_engine         (register_stack_engine),
	.front_end_thread              (front_end_thread),
	.back_end_thread               (back_end_thread),
	.pipe_continuous               (pipe_continuous),
	.explicit_disable              (explicit_disable),
	.implicit_disable              (implicit_disable),
	.backend_switch_disabled_event (backend_switch_disabled_event),
	.backend_switch_dropped_event  (backend_switch_dropped_event),
	.backend_switch_held_event     (backend_switch_held_event),
	.backend_switch_stall_event    (backend_switch_stall_event),
	.front_back_same_thread_event  (front_back_same_thread_event),
	.cnt_inc                       (cnt_inc)
);

/* bench/tsem_cnt_model.sv */
// counter bank at the far side: totals accepted increments
`timescale 1ns/1ps
module tsem_cnt_model #(parameter NUM_CNT = 5) (
	input wire logic               mclk,
	input wire logic               rst_n,
	input wire logic [NUM_CNT-1:0] cnt_inc,
	output int                     total
);
	always @(posedge mclk or negedge rst_n)
		if (!rst_n) total <= 0;
		else total <= total + $countones(cnt_inc);
endmodule

/* bench/tsem_monitor_tb_top.sv */
// self-checking bench for the thread-switch event monitor
`timescale 1ns/1ps
module tsem_monitor_tb_top;
	logic mclk = 0, rst_n = 0, switch_disable_bit, drop_policy, drop_full_slice, drop_wait_window, switch_pending;
	logic hold_camping, hold_rare, stall_pipe, stall_in_switch, register_conflict_blocker, floating_load_blocker;
	logic register_stack_engine, front_end_thread, back_end_thread, pipe_continuous, explicit_disable;
	logic implicit_disable, backend_switch_disabled_event, backend_switch_dropped_event, backend_switch_held_event;
	logic backend_switch_stall_event, front_back_same_thread_event;
	logic [1:0]   low_power_state;
	logic [239:0] cnt_sel = '0;
	logic [19:0]  cnt_inc;
	logic [26:0]  q[$];
	logic [11:0]  codes[12] = '{12'h0139, 12'h013a, 12'h013b, 12'h013c, 12'h013d, 12'h013e, 12'h013f, 12'h0140,
		12'h0141, 12'h0142, 12'h0874, 12'h0000};
	int total, acc = 0, n_fail = 0, check_count = 0;
	tsem_monitor #(
		.NUM_CNT (20)
	) tsem_monitor_i (
		.mclk                          (mclk),
		.rst_n                         (rst_n),
		.low_power_state               (low_power_state),
		.switch_disable_bit            (switch_disable_bit),
		.drop_policy                   (drop_policy),
		.drop_full_slice               (drop_full_slice),
		.drop_wait_window              (drop_wait_window),
		.switch_pending                (switch_pending),
		.hold_camping                  (hold_camping),
		.hold_rare                     (hold_rare),
		.stall_pipe                    (stall_pipe),
		.stall_in_switch               (stall_in_switch),
		.register_conflict_blocker     (register_conflict_blocker),
		.floating_load_blocker         (floating_load_blocker),
		.register_stack_engine         (register_stack_engine),
		.front_end_thread              (front_end_thread),
		.back_end_thread               (back_end_thread),
		.pipe_continuous               (pipe_continuous),
		.cnt_sel                       (cnt_sel),
		.explicit_disable              (explicit_disable),
		.implicit_disable              (implicit_disable),
		.backend_switch_disabled_event (backend_switch_disabled_event),
		.backend_switch_dropped_event  (backend_switch_dropped_event),
		.backend_switch_held_event     (backend_switch_held_event),
		.backend_switch_stall_event    (backend_switch_stall_event),
		.front_back_same_thread_event  (front_back_same_thread_event),
		.cnt_inc                       (cnt_inc)
	);
	tsem_cnt_model #(
		.NUM_CNT (20)
	) tsem_cnt_model_i (
		.mclk    (mclk),
		.rst_n   (rst_n),
		.cnt_inc (cnt_inc),
		.total   (total)
	);
	initial forever #12.5 mclk = ~mclk;
	task automatic put(input logic [16:0] v);
		{low_power_state, switch_disable_bit, drop_policy, drop_full_slice, drop_wait_window, switch_pending,
		hold_camping, hold_rare, stall_pipe, stall_in_switch, register_conflict_blocker, floating_load_blocker,
		register_stack_engine, front_end_thread, back_end_thread, pipe_continuous} = v;
	endtask
	function automatic logic [26:0] expv();
		logic [6:0] e;
		logic [19:0] m, n;
		logic [11:0] c;
		e = {|low_power_state, switch_disable_bit, |low_power_state | switch_disable_bit,
			drop_policy | drop_full_slice | drop_wait_window, switch_pending & (hold_camping | hold_rare),
			stall_pipe | stall_in_switch | register_conflict_blocker | floating_load_blocker | register_stack_engine,
			(front_end_thread == back_end_thread) & pipe_continuous};
		for (int g = 0; g < 20; g++) begin
			c = cnt_sel[12*g+:12];
			m = (c == 12'h0874) ? 20'h5_0550 : c[0] ? 20'ha_aaa0 : 20'h5_5550;
			case (c)
				12'h0139: n[g] = e[3] & m[g];
				12'h013a: n[g] = e[6] & m[g];
				12'h013b: n[g] = e[5] & m[g];
				12'h013c: n[g] = e[2] & m[g];
				12'h013d: n[g] = e[1] & m[g];
				12'h013e: n[g] = stall_in_switch & m[g];
				12'h013f: n[g] = stall_pipe & m[g];
				12'h0140: n[g] = register_stack_engine & m[g];
				12'h0141: n[g] = register_conflict_blocker & m[g];
				12'h0142: n[g] = floating_load_blocker & m[g];
				12'h0874: n[g] = e[0] & m[g];
				default: n[g] = 1'b0;
			endcase
		end
		return {e, n};
	endfunction
	task automatic cmp(input logic [31:0] x, input logic [31:0] y);
		check_count++;
		if (x !== y) begin
			n_fail++;
			$display("CHECK FAILED t=%0t exp=%h act=%h", $time, x, y);
		end
	endtask
	task automatic step(input logic [16:0] v, input logic [239:0] sel);
		logic [26:0] e;
		@(negedge mclk);
		cnt_sel = sel;
		put(v);
		e = expv();
		q.push_back(e);
		acc += $countones(e[19:0]);
	endtask
	task automatic test_done;
		$display("checks %0d failures %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	initial forever begin
		@(posedge mclk);
		#1;
		if (q.size() > 0) cmp(q.pop_front(), {explicit_disable, implicit_disable, backend_switch_disabled_event,
			backend_switch_dropped_event, backend_switch_held_event, backend_switch_stall_event,
			front_back_same_thread_event, cnt_inc});
	end
	initial begin
		#1ms;
		n_fail++;
		test_done();
	end
	initial begin
		logic [239:0] s;
		put('0);
		void'($urandom(32'h69a3_96bc));
		repeat (5) @(negedge mclk);
		rst_n = 1;
		for (int c = 0; c < 12; c++) begin
			for (int g = 0; g < 20; g++) s[12*g+:12] = codes[(c+g)%12];
			step(17'h1_ffff, s);
			step(17'h0_0000, s);
		end
		$display("code sweep done");
		for (int i = 0; i < 600; i++) begin
			for (int g = 0; g < 20; g++) s[12*g+:12] = codes[$urandom%12];
			step(17'($urandom), s);
		end
		step(17'h0_0000, '0);
		$display("random traffic done");
		repeat (3) @(negedge mclk);
		cmp(32'(q.size()), 32'h0000_0000);
		cmp(acc, total);
		test_done();
	end
endmodule
